/* trace_trigger_pkg.sv */
`default_nettype none
package trace_trigger_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_OCCUR    = 8'h04;
  localparam logic [7:0] A_POS_OFF  = 8'h08;
  localparam logic [7:0] A_TRIG_VAL = 8'h0C;
  localparam logic [7:0] A_TRIG_MSK = 8'h10;
  localparam logic [7:0] A_STO_VAL  = 8'h14;
  localparam logic [7:0] A_STO_MSK  = 8'h18;
  localparam logic [7:0] A_PRE_VAL  = 8'h1C;
  localparam logic [7:0] A_PRE_MSK  = 8'h20;
  localparam logic [7:0] A_STATUS   = 8'h24;
  localparam logic [7:0] A_IRQ_STAT = 8'h28;
  localparam logic [7:0] A_IRQ_CLR  = 8'h2C;
  localparam logic [7:0] A_IRQ_EN   = 8'h30;
  localparam logic [7:0] A_RD_ADDR  = 8'h34;
  localparam logic [7:0] A_RD_DATA  = 8'h38;
  localparam logic [7:0] A_RD_TAG   = 8'h3C;
  // Control register fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_CQ     = 2;
  localparam int CTRL_POS    = 4;
  localparam int CTRL_STO_EN = 7;
  localparam int CTRL_PRE_EN = 8;
  localparam logic [8:0] CTRL_RESET   = 9'h004;
  localparam logic [8:0] CTRL_KEEP    = 9'h1FC;
  // Count qualifier modes
  localparam logic [1:0] CQ_NONE  = 2'h0;
  localparam logic [1:0] CQ_TIME  = 2'h1;
  localparam logic [1:0] CQ_STATE = 2'h2;
  // Trigger position modes
  localparam logic [2:0] POS_START  = 3'h0;
  localparam logic [2:0] POS_CENTRE = 3'h1;
  localparam logic [2:0] POS_END    = 3'h2;
  localparam logic [2:0] POS_BEFORE = 3'h3;
  localparam logic [2:0] POS_AFTER  = 3'h4;
  // Trace memory
  localparam int ADDR_W = 10;
  localparam int TAG_W  = 16;
  localparam logic [10:0] DEPTH_NOCOUNT = 11'h400;
  localparam logic [10:0] DEPTH_COUNT   = 11'h200;
  localparam logic [15:0] PRESTORE_TAG  = 16'hFFFF;
  localparam logic [15:0] TAG_MAX       = 16'hFFFE;
  // Occurrence count
  localparam logic [15:0] OCC_RESET = 16'h0001;
  localparam logic [15:0] OCC_MIN   = 16'h0001;
  // Interrupt bits
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_DONE = 1;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* state_qualifier_match.sv */
`default_nettype none
module state_qualifier_match #(
  parameter int SW = 32
) (
  // Qualifier setup
  input  wire logic          enable,
  input  wire logic          idle_hit,
  input  wire logic [SW-1:0] value,
  input  wire logic [SW-1:0] mask,
  // Captured state
  input  wire logic [SW-1:0] data,
  output logic               hit
);
  // Masked compare; a cleared mask bit is a don't-care
  always_comb begin
    if (enable) begin
      hit = ((data ^ value) & mask) == '0;
    end else begin
      hit = idle_hit;
    end
  end
endmodule // state_qualifier_match
`default_nettype wire

/* trace_trigger_store_qualifier.sv */
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
// How it works
// R1 - The trigger fires on the Nth qualifying state, N being the programmed occurrence count.
// R2 - The occurrence count is 16 bits and a written zero is taken as one, so it spans 1 to 65535.
// R3 - The trigger lands at start, centre or end of memory, and at start when nothing is chosen.
// R4 - A programmed number of states may instead stand before or after the trigger.
// R5 - With time or state counting on, the trigger sits within one state of its programmed place.
// R6 - With counting off, the trigger sits within three states of its programmed place.
// R7 - Every captured state is stored unless a storage qualifier limits storage to its matches.
// R8 - The trigger state is always stored, even when the storage qualifier rejects it.
// R9 - With prestore on, the last two prestore matches are stored ahead of the next normal store.
// R10 - Prestore is off after reset until software enables a prestore qualifier.
// R11 - A state matching both storage and prestore qualifiers is stored as a normal state.
// R12 - Prestore entries carry a prestore marker in the count tag instead of a count.
// R13 - The count of a normal state runs from the previous normal store, skipping prestores.
// R14 - Counting off keeps prestore capture working and only drops the visible marker.
// R15 - Starting a run reloads the occurrence counter with the programmed count and clears the prestore buffer.
module trace_trigger_store_qualifier #(
  parameter int SW = 32
) (
  // Clock, reset and enable
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  // Captured bus states
  input  wire logic          state_valid,
  input  wire logic [SW-1:0] state_data,
  // AXI4-Lite write channels
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [7:0]    awaddr,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output logic               bvalid,
  input  wire logic          bready,
  output logic [1:0]         bresp,
  // AXI4-Lite read channels
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [7:0]    araddr,
  output logic               rvalid,
  input  wire logic          rready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  // Status outputs
  output logic               irq,
  output logic               triggered,
  output logic               run_active
);
  localparam int AW = trace_trigger_pkg::ADDR_W;
  localparam int TW = trace_trigger_pkg::TAG_W;
  localparam int NMEM = 1 << AW;

  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_POST} run_e;

  ////////////////////////////////////////////////////////////////////////////
  // State and next values
  logic [8:0]    ctrl, next_ctrl;
  logic [15:0]   occ, next_occ;
  logic [AW-1:0] pos_off, next_pos_off;
  logic [SW-1:0] tv, next_tv, tm, next_tm, sv, next_sv, sm, next_sm, pv, next_pv, pm, next_pm;
  logic [1:0]    irq_st, next_irq_st, irq_en, next_irq_en;
  logic [AW-1:0] rd_addr, next_rd_addr;
  run_e          st, next_st;
  logic [15:0]   occ_left, next_occ_left;
  logic [AW-1:0] post_left, next_post_left, wp, next_wp, trig_addr, next_trig_addr;
  logic [TW-1:0] ctr, next_ctr;
  logic [SW-1:0] pre0, next_pre0, pre1, next_pre1;
  logic [1:0]    pcnt, next_pcnt;
  logic          next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]    next_bresp, next_rresp;
  logic [31:0]   next_rdata, w_data, next_w_data;
  logic [7:0]    aw_addr, next_aw_addr;
  logic [3:0]    w_strb, next_w_strb;
  logic          next_irq, next_triggered, next_run_active;

  // Trace memory and its write lanes
  logic [SW-1:0] mem_d [NMEM];
  logic [TW-1:0] mem_t [NMEM];
  logic [2:0]    lane_en;
  logic [AW-1:0] lane_a [3];
  logic [SW-1:0] lane_d [3];
  logic [TW-1:0] lane_t [3];

  // Helpers
  logic          hit_t, hit_s, hit_p, take, fire, store, wr_go, start;
  logic [AW:0]   depth, last, post_full;
  logic [AW-1:0] dmask, post;
  logic [31:0]   wv;
  logic [1:0]    cq;
  logic [2:0]    pos;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into the old register value
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Qualifier compares; storage defaults to all, prestore to none
  state_qualifier_match #(.SW(SW)) u_trig (
    .enable(1'b1), .idle_hit(1'b0), .value(tv), .mask(tm), .data(state_data), .hit(hit_t)
  );
  state_qualifier_match #(.SW(SW)) u_sto (
    .enable(ctrl[trace_trigger_pkg::CTRL_STO_EN]), .idle_hit(1'b1), .value(sv), .mask(sm),
    .data(state_data), .hit(hit_s)
  );
  state_qualifier_match #(.SW(SW)) u_pre (
    .enable(ctrl[trace_trigger_pkg::CTRL_PRE_EN]), .idle_hit(1'b0), .value(pv), .mask(pm),
    .data(state_data), .hit(hit_p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Position arithmetic; counting halves the memory since tags need room
  always_comb begin
    cq = ctrl[trace_trigger_pkg::CTRL_CQ +: 2];
    pos = ctrl[trace_trigger_pkg::CTRL_POS +: 3];
    depth = (cq == trace_trigger_pkg::CQ_NONE) ? trace_trigger_pkg::DEPTH_NOCOUNT
                                              : trace_trigger_pkg::DEPTH_COUNT;
    last = depth - {{AW{1'b0}}, 1'b1};
    dmask = last[AW-1:0];
    // States stored after the trigger; the stop is exact, inside both tolerances
    unique case (pos)
      trace_trigger_pkg::POS_CENTRE: post_full = (depth >> 1) - {{AW{1'b0}}, 1'b1}; // see R3 R5 R6
      trace_trigger_pkg::POS_END:    post_full = '0; // see R3
      trace_trigger_pkg::POS_BEFORE: post_full = ({1'b0, pos_off} >= last) ? '0
                                                 : last - {1'b0, pos_off}; // see R4
      trace_trigger_pkg::POS_AFTER:  post_full = ({1'b0, pos_off} > last) ? last
                                                 : {1'b0, pos_off}; // see R4
      default:                       post_full = last; // see R3
    endcase
    post = post_full[AW-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, registers and run control
  always_comb begin
    next_ctrl = ctrl; next_occ = occ; next_pos_off = pos_off;
    next_tv = tv; next_tm = tm; next_sv = sv; next_sm = sm; next_pv = pv; next_pm = pm;
    next_irq_en = irq_en; next_rd_addr = rd_addr;
    next_st = st; next_occ_left = occ_left; next_post_left = post_left; next_wp = wp;
    next_trig_addr = trig_addr; next_ctr = ctr; next_pre0 = pre0; next_pre1 = pre1;
    next_pcnt = pcnt; next_triggered = triggered;
    next_awready = awready; next_wready = wready; next_bvalid = bvalid; next_bresp = bresp;
    next_arready = arready; next_rvalid = rvalid; next_rdata = rdata; next_rresp = rresp;
    next_aw_addr = aw_addr; next_w_data = w_data; next_w_strb = w_strb;
    lane_en = '0;
    for (int i = 0; i < 3; i++) begin
      lane_a[i] = '0;
      lane_d[i] = '0;
      lane_t[i] = '0;
    end
    // Address and data are latched in either order; the write runs once both are held
    if (awvalid && awready) begin
      next_awready = 1'b0;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_wready = 1'b0;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    wr_go = !awready && !wready && !bvalid;
    start = 1'b0;
    wv = '0;
    next_irq_st = irq_st;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = trace_trigger_pkg::RESP_OKAY;
      unique case ({aw_addr[7:2], 2'h0})
        trace_trigger_pkg::A_CTRL: begin
          wv = wmerge({23'h0, ctrl}, w_data, w_strb);
          next_ctrl = wv[8:0] & trace_trigger_pkg::CTRL_KEEP;
          start = w_strb[0] && w_data[trace_trigger_pkg::CTRL_START];
          if (w_strb[0] && w_data[trace_trigger_pkg::CTRL_STOP]) next_st = ST_IDLE;
        end
        trace_trigger_pkg::A_OCCUR: begin
          wv = wmerge({16'h0, occ}, w_data, w_strb);
          next_occ = (wv[15:0] == '0) ? trace_trigger_pkg::OCC_MIN : wv[15:0]; // see R2
        end
        trace_trigger_pkg::A_POS_OFF: begin
          wv = wmerge(32'(pos_off), w_data, w_strb);
          next_pos_off = wv[AW-1:0];
        end
        trace_trigger_pkg::A_TRIG_VAL: next_tv = SW'(wmerge(32'(tv), w_data, w_strb));
        trace_trigger_pkg::A_TRIG_MSK: next_tm = SW'(wmerge(32'(tm), w_data, w_strb));
        trace_trigger_pkg::A_STO_VAL:  next_sv = SW'(wmerge(32'(sv), w_data, w_strb));
        trace_trigger_pkg::A_STO_MSK:  next_sm = SW'(wmerge(32'(sm), w_data, w_strb));
        trace_trigger_pkg::A_PRE_VAL:  next_pv = SW'(wmerge(32'(pv), w_data, w_strb));
        trace_trigger_pkg::A_PRE_MSK:  next_pm = SW'(wmerge(32'(pm), w_data, w_strb));
        trace_trigger_pkg::A_IRQ_CLR:  next_irq_st = irq_st & ~(w_data[1:0] & {2{w_strb[0]}});
        trace_trigger_pkg::A_IRQ_EN: begin
          if (w_strb[0]) next_irq_en = w_data[1:0];
        end
        trace_trigger_pkg::A_RD_ADDR: begin
          wv = wmerge(32'(rd_addr), w_data, w_strb);
          next_rd_addr = wv[AW-1:0];
        end
        trace_trigger_pkg::A_STATUS, trace_trigger_pkg::A_IRQ_STAT,
        trace_trigger_pkg::A_RD_DATA, trace_trigger_pkg::A_RD_TAG: ;
        default: next_bresp = trace_trigger_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    // Reads answer one cycle after the address is taken
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = trace_trigger_pkg::RESP_OKAY;
      unique case ({araddr[7:2], 2'h0})
        trace_trigger_pkg::A_CTRL:     next_rdata = {23'h0, ctrl};
        trace_trigger_pkg::A_OCCUR:    next_rdata = {16'h0, occ};
        trace_trigger_pkg::A_POS_OFF:  next_rdata = 32'(pos_off);
        trace_trigger_pkg::A_TRIG_VAL: next_rdata = 32'(tv);
        trace_trigger_pkg::A_TRIG_MSK: next_rdata = 32'(tm);
        trace_trigger_pkg::A_STO_VAL:  next_rdata = 32'(sv);
        trace_trigger_pkg::A_STO_MSK:  next_rdata = 32'(sm);
        trace_trigger_pkg::A_PRE_VAL:  next_rdata = 32'(pv);
        trace_trigger_pkg::A_PRE_MSK:  next_rdata = 32'(pm);
        trace_trigger_pkg::A_STATUS:
          next_rdata = {1'b0, trig_addr, occ_left, 1'b0, triggered, st != ST_IDLE, pcnt};
        trace_trigger_pkg::A_IRQ_STAT: next_rdata = {30'h0, irq_st};
        trace_trigger_pkg::A_IRQ_CLR:  next_rdata = '0;
        trace_trigger_pkg::A_IRQ_EN:   next_rdata = {30'h0, irq_en};
        trace_trigger_pkg::A_RD_ADDR:  next_rdata = 32'(rd_addr);
        trace_trigger_pkg::A_RD_DATA:  next_rdata = 32'(mem_d[rd_addr]);
        trace_trigger_pkg::A_RD_TAG:   next_rdata = 32'(mem_t[rd_addr]);
        default: begin
          next_rdata = '0;
          next_rresp = trace_trigger_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    // Count tag runs from the last normal store; prestores do not restart it
    if (cq == trace_trigger_pkg::CQ_TIME || (cq == trace_trigger_pkg::CQ_STATE && state_valid)) begin
      if (ctr != trace_trigger_pkg::TAG_MAX) next_ctr = ctr + 1'b1;
    end
    // Captured state handling while a run is live
    take = state_valid && st != ST_IDLE && !start;
    fire = take && st == ST_SEEK && hit_t && occ_left == trace_trigger_pkg::OCC_MIN; // see R1
    store = take && (hit_s || fire); // see R7 R8
    if (take && st == ST_SEEK && hit_t && !fire) next_occ_left = occ_left - 1'b1; // see R1
    if (store) begin
      // Held prestores go first, oldest lowest, then the normal state
      for (int i = 0; i < 3; i++) begin
        lane_a[i] = (wp + AW'(i)) & dmask;
        if (i < int'(pcnt)) begin
          lane_en[i] = 1'b1; // see R9
          lane_d[i] = (i == 0) ? pre0 : pre1;
          lane_t[i] = (cq == trace_trigger_pkg::CQ_NONE) ? '0
                      : trace_trigger_pkg::PRESTORE_TAG; // see R12 R14
        end else if (i == int'(pcnt)) begin
          lane_en[i] = 1'b1;
          lane_d[i] = state_data;
          lane_t[i] = (cq == trace_trigger_pkg::CQ_NONE) ? '0 : ctr; // see R13
        end
      end
      next_wp = (wp + AW'(pcnt) + 1'b1) & dmask;
      next_pcnt = '0;
      next_ctr = '0; // see R13
      if (st == ST_POST) begin
        if (post_left == AW'(1)) next_st = ST_IDLE;
        next_post_left = post_left - 1'b1;
      end
    end else if (take && hit_p) begin
      // Only the two newest prestore matches are kept; storage match wins above
      if (pcnt == 2'h0) next_pre0 = state_data; // see R9 R11
      else if (pcnt == 2'h1) next_pre1 = state_data;
      else begin
        next_pre0 = pre1;
        next_pre1 = state_data;
      end
      if (pcnt != 2'h2) next_pcnt = pcnt + 1'b1;
    end
    if (fire) begin
      next_trig_addr = (wp + AW'(pcnt)) & dmask;
      next_triggered = 1'b1;
      next_post_left = post;
      next_st = (post == '0) ? ST_IDLE : ST_POST; // see R3 R4
    end
    // A fresh run reloads the occurrence count from occ and clears any held prestores
    if (start) begin
      next_st = ST_SEEK;
      next_occ_left = occ; // see R15
      next_pcnt = '0; // see R15
      next_wp = '0;
      next_ctr = '0;
      next_post_left = '0;
      next_triggered = 1'b0;
    end
    // Hardware set wins over a clear in the same cycle
    next_irq_st[trace_trigger_pkg::IRQ_TRIG] = next_irq_st[trace_trigger_pkg::IRQ_TRIG] | fire;
    next_irq_st[trace_trigger_pkg::IRQ_DONE] = next_irq_st[trace_trigger_pkg::IRQ_DONE]
                                            | (st != ST_IDLE && next_st == ST_IDLE && !start);
    next_irq = |(next_irq_st & next_irq_en);
    next_run_active = next_st != ST_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage; prestore enable resets off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= trace_trigger_pkg::CTRL_RESET; // see R10
      occ <= trace_trigger_pkg::OCC_RESET;
      pos_off <= '0;
      tv <= '0; tm <= '0; sv <= '0; sm <= '0; pv <= '0; pm <= '0;
      irq_st <= '0; irq_en <= '0; rd_addr <= '0;
      st <= ST_IDLE; occ_left <= '0; post_left <= '0; wp <= '0; trig_addr <= '0;
      ctr <= '0; pre0 <= '0; pre1 <= '0; pcnt <= '0;
      awready <= 1'b1; wready <= 1'b1; bvalid <= 1'b0; bresp <= '0;
      arready <= 1'b1; rvalid <= 1'b0; rdata <= '0; rresp <= '0;
      aw_addr <= '0; w_data <= '0; w_strb <= '0;
      irq <= 1'b0; triggered <= 1'b0; run_active <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl; occ <= next_occ; pos_off <= next_pos_off;
      tv <= next_tv; tm <= next_tm; sv <= next_sv; sm <= next_sm; pv <= next_pv; pm <= next_pm;
      irq_st <= next_irq_st; irq_en <= next_irq_en; rd_addr <= next_rd_addr;
      st <= next_st; occ_left <= next_occ_left; post_left <= next_post_left;
      wp <= next_wp; trig_addr <= next_trig_addr;
      ctr <= next_ctr; pre0 <= next_pre0; pre1 <= next_pre1; pcnt <= next_pcnt;
      awready <= next_awready; wready <= next_wready; bvalid <= next_bvalid; bresp <= next_bresp;
      arready <= next_arready; rvalid <= next_rvalid; rdata <= next_rdata; rresp <= next_rresp;
      aw_addr <= next_aw_addr; w_data <= next_w_data; w_strb <= next_w_strb;
      irq <= next_irq; triggered <= next_triggered; run_active <= next_run_active;
    end
  end

  // Trace memory writes, up to three entries per state; no reset so it maps to RAM
  always_ff @(posedge aclk) begin
    if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (lane_en[i]) begin
          mem_d[lane_a[i]] <= lane_d[i];
          mem_t[lane_a[i]] <= lane_t[i];
        end
      end
    end
  end
endmodule // trace_trigger_store_qualifier
`default_nettype wire

/* trace_trigger_checker_sva.sv */
`default_nettype none
module trace_trigger_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes and read data
  input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic        arvalid, arready, rvalid, rready,
  input wire logic [31:0] rdata,
  // Captured states and run status
  input wire logic        state_valid, triggered, run_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Trigger timing against the state stream and the start write
  property p_trig_cause; $rose(triggered) |-> $past(state_valid) && $past(run_active); endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("trigger without a state");
  property p_trig_clear; $fell(triggered) |-> bvalid; endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger lost without start");
  ////////////////////////////////////////////////////////////////////////////
  // Register bus answers, so a stuck slave cannot hide a lost write
  property p_b_lat; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_b_hold; bvalid && !bready |=> bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_block; bvalid |-> !awready && !wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while answering");
  property p_r_lat; arvalid && arready |=> rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed");
  property p_r_block; rvalid |-> !arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read taken while answering");
endmodule // trace_trigger_checker
bind trace_trigger_store_qualifier trace_trigger_checker i_chk (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata,
  .state_valid, .triggered, .run_active);
`default_nettype wire

/* state_source.sv */
`default_nettype none
module state_source (
  // Clock
  input wire logic        aclk,
  // Burst request from the bench
  input wire logic        go,
  input wire logic [15:0] n,
  input wire logic [31:0] base,
  // Captured states toward the block
  output var logic        state_valid,
  output var logic [31:0] state_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left = 16'h0;
  initial state_valid = 1'h0;
  initial state_data = 32'h0;
  // One state a cycle; idle data flips so a stale word never looks valid
  always @(posedge aclk) begin
    if (go) begin
      state_valid <= 1'h1;
      state_data  <= base;
      left        <= n - 16'h1;
    end else if (state_valid && left != 16'h0) begin
      state_data <= state_data + 32'h1;
      left       <= left - 16'h1;
    end else begin
      state_valid <= 1'h0;
      state_data  <= ~state_data;
    end
  end
endmodule // state_source
`default_nettype wire

/* tb_trace_trigger_store_qualifier.sv */
`default_nettype none
module tb_trace_trigger_store_qualifier;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, go = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, triggered, run_active, state_valid;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, base = 32'h0, rdata, state_data, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [15:0] n = 16'h0;
  int miscompares = 0, n_checks = 0;
  always #2.5 aclk = ~aclk;
  state_source i_src (.aclk, .go, .n, .base, .state_valid, .state_data);
  trace_trigger_store_qualifier i_dut (.aclk, .aresetn, .ce, .state_valid, .state_data,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .irq, .triggered, .run_active);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Each bus task waits an edge first so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic b_on;
    b_on = 1'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int k = 0; k < 64 && b_on; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        b_on = 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
    if (b_on) miscompares++;
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er = 2'h0);
    logic r_on;
    r_on = 1'h1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int k = 0; k < 64 && r_on; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        r_on = 1'h0;
        rd = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
    if (r_on) miscompares++;
  endtask
  // Burst of cnt states counting up from b; returns two edges after the last state is taken
  task automatic send(input logic [31:0] b, input logic [15:0] cnt);
    @(posedge aclk);
    base <= b;
    n <= cnt;
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    for (int k = 0; k < 2000 && (go || state_valid); k++) @(posedge aclk);
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdr(8'h00);
    chk("ctrl", 32'h4, rd);
    rdr(8'h04);
    chk("occur", 32'h1, rd);
    rdr(8'h24);
    chk("prestores held", 32'h0, {30'h0, rd[1:0]});
    wr(8'h04, 32'hFFFF);
    rdr(8'h04);
    chk("occur max", 32'hFFFF, rd);
    rdr(8'hF0, 2'h2);
    wr(8'hF0, 32'h0, 2'h2);
    $display("test reset done");
  endtask
  task automatic t_occur;
    wr(8'h04, 32'h3);
    wr(8'h30, 32'h1);
    wr(8'h00, 32'h5);
    rdr(8'h24);
    chk("occurrence left", 32'h3, {16'h0, rd[20:5]});
    send(32'h10, 16'h2);
    chk("early trigger", 32'h0, {31'h0, triggered});
    send(32'h20, 16'h1);
    chk("triggered", 32'h1, {31'h0, triggered});
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h30, 32'h0);
    @(posedge aclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(8'h2C, 32'h1);
    wr(8'h30, 32'h1);
    @(posedge aclk);
    chk("cleared irq", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h6);
    $display("test occurrence done");
  endtask
  // Trigger fails storage, then three prestore states and one normal store
  task automatic t_store(input logic [31:0] cq);
    logic [9:0] ta;
    logic [31:0] et;
    wr(8'h04, 32'h1);
    wr(8'h18, 32'h3);
    wr(8'h00, cq | 32'h181);
    @(posedge aclk);
    chk("start clears trigger", 32'h0, {31'h0, triggered});
    send(32'h101, 16'h1);
    send(32'h105, 16'h4);
    wr(8'h00, cq | 32'h182);
    rdr(8'h24);
    ta = rd[30:21];
    et = (cq == 32'h8) ? 32'h3 : (cq == 32'h4 ? 32'h7 : 32'h0); // States or cycles since trigger
    for (int k = 0; k < 4; k++) begin
      wr(8'h34, {22'h0, ta + 10'(k)} & (cq != 0 ? 32'h1FF : 32'h3FF));
      rdr(8'h38);
      chk("stored", k == 0 ? 32'h101 : 32'h105 + k, rd);
      rdr(8'h3C);
      if (k > 0) chk("tag", k < 3 ? (cq != 0 ? 32'hFFFF : 32'h0) : et, rd);
    end
    $display("test store done");
  endtask
  // A burst of a_on states, the first one the trigger, keeps the run going; more states must end it
  task automatic t_pos(input logic [31:0] cq, p, input logic [15:0] a_on, more);
    wr(8'h08, 32'h5);
    wr(8'h00, cq | p);
    send(32'h200, a_on);
    chk("run active", 32'h1, {31'h0, run_active});
    send(32'h300, more);
    chk("run ended", 32'h0, {31'h0, run_active});
    $display("test position done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_occur;
    t_store(32'h4);
    t_store(32'h0);
    t_store(32'h8);
    t_pos(32'h4, 32'h41, 16'h4, 16'h3);
    t_pos(32'h0, 32'h41, 16'h2, 16'h7);
    // Before 5 leaves 506 after, within one; centre leaves 511 after, within three
    t_pos(32'h4, 32'h31, 16'h1F9, 16'h3);
    t_pos(32'h0, 32'h11, 16'h1FC, 16'h7);
    complete_run;
  end
endmodule // tb_trace_trigger_store_qualifier
`default_nettype wire
